/* rtl/pmm_ctrl.sv */
// Purpose: Paged memory map controller: arbitration, translation,
//          protection and parity between requesters and core modules.
// Assumes: Requesters and core modules are logic on the same clock.
// Notes:   One access accepted per clock; accesses to different modules overlap.
//
// Operation
// - Logical 32K or 65K words, physical core modules
// - Core managed in 256-word pages
// - Any logical page maps to any physical page
// - Map registers relocate every memory reference
// - Page codes: none, read only, read-write
// - All requesters, including I/O, are mapped
// - Simultaneous requests granted by fixed priority
// - Parity generated and stored on writes
// - Parity checked on every core read
// - Parity error aborts read, traps processor
// - Sixteen 4096-word modules, overlapped accesses allowed
// - Map mode taken from status doubleword
module pmm_ctrl
    import pmm_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire pmm_req_t i_disc,
    input wire pmm_req_t i_dac,
    input wire pmm_req_t i_cpu,
    input wire logic [31:0] i_psd,
    input wire logic i_map_wr,
    input wire logic [7:0] i_map_idx,
    input wire pmm_map_t i_map_ent,
    input wire logic [15:0] i_core_busy,
    input wire logic i_core_rvalid,
    input wire logic [3:0] i_core_rmod,
    input wire logic [16:0] i_core_rdata,
    output pmm_core_t o_core,
    output logic [2:0] o_gnt,
    output logic [2:0] o_rvalid,
    output logic [15:0] o_rdata,
    output logic [2:0] o_err,
    output logic o_trap,
    output logic [1:0] o_trap_cause
);
    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    pmm_core_t core_reg;
    logic [2:0] gnt_reg;
    logic [2:0] rvalid_reg;
    logic [15:0] rdata_reg;
    logic [2:0] err_reg;
    logic trap_reg;
    logic [1:0] cause_reg;
    logic [15:0] pend_reg;
    logic [1:0] owner_reg [NUM_MODS];

    logic [2:0] req_vec;
    logic [2:0] sel_oh;
    logic [1:0] sel_id;
    pmm_req_t sel;
    pmm_map_t map_ent;
    logic map_on;
    logic [15:0] phys;
    logic [3:0] mod;
    logic viol;
    logic mod_free;
    logic accept;
    logic issue;
    logic par_bad;
    logic [1:0] rv_owner;
    logic [2:0] rv_oh;

    // ---------------------------------------------------------------
    // Arbitration and translation
    // ---------------------------------------------------------------
    // A requester just granted is masked for one cycle so a held request
    // is not taken twice
    assign req_vec = {i_cpu.req, i_dac.req, i_disc.req} & ~gnt_reg;

    // Fixed priority: disc, then channel, then processor
    always_comb begin
        sel_oh = 3'h0;
        sel_id = ID_CPU;
        sel = i_cpu;
        if (req_vec[0]) begin
            sel_oh = OH_DISC;
            sel_id = ID_DISC;
            sel = i_disc;
        end else if (req_vec[1]) begin
            sel_oh = OH_DAC;
            sel_id = ID_DAC;
            sel = i_dac;
        end else if (req_vec[2]) begin
            sel_oh = OH_CPU;
            sel_id = ID_CPU;
            sel = i_cpu;
        end
    end

    pmm_map_ram u_map (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_wr(i_map_wr),
        .i_widx(i_map_idx),
        .i_went(i_map_ent),
        .i_ridx(sel.addr[15:8]),
        .o_rent(map_ent)
    );

    assign map_on = i_psd[PSD_MAP_BIT];
    // Page number replaced, word-in-page offset kept
    assign phys = map_on ? {map_ent.page, sel.addr[7:0]} : sel.addr;
    assign mod = phys[15:12];

    // Protection applies to whichever requester won, I/O included
    always_comb begin
        viol = 1'b0;
        if (map_on) begin
            if (map_ent.prot != PROT_RW && map_ent.prot != PROT_RO) begin
                viol = 1'b1;
            end else if (map_ent.prot == PROT_RO && sel.we) begin
                viol = 1'b1;
            end
            if (!EXT_OPT && sel.addr[15]) begin
                viol = 1'b1;
            end
        end
    end

    // A module with a read outstanding is held off so returns stay unambiguous
    assign mod_free = ~i_core_busy[mod] & ~pend_reg[mod];
    assign accept = (|sel_oh) & (viol | mod_free);
    assign issue = accept & ~viol;

    // ---------------------------------------------------------------
    // Outstanding reads per module
    // ---------------------------------------------------------------
    for (genvar g = 0; g < NUM_MODS; g++) begin : g_mod
        // Set beats clear; same-module set and return cannot coincide anyway
        always_ff @(posedge i_ref_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                pend_reg[g] <= 1'b0;
                owner_reg[g] <= ID_DISC;
            end else if (issue && !sel.we && mod == 4'(g)) begin
                pend_reg[g] <= 1'b1;
                owner_reg[g] <= sel_id;
            end else if (i_core_rvalid && i_core_rmod == 4'(g)) begin
                pend_reg[g] <= 1'b0;
            end
        end
    end

    // Odd parity over 17 bits: an even count of ones means corruption
    assign par_bad = PAR_OPT & ~(^i_core_rdata);
    assign rv_owner = owner_reg[i_core_rmod];
    assign rv_oh = 3'(3'h1 << rv_owner);

    // ---------------------------------------------------------------
    // Core command
    // ---------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            core_reg <= '0;
        end else begin
            core_reg.valid <= issue;
            core_reg.we <= sel.we;
            core_reg.mod <= mod;
            core_reg.addr <= phys[11:0];
            core_reg.wdata <= {~^sel.wdata, sel.wdata};
        end
    end

    // ---------------------------------------------------------------
    // Requester answers
    // ---------------------------------------------------------------
    // Grants and aborts
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            gnt_reg <= 3'h0;
            err_reg <= 3'h0;
        end else begin
            gnt_reg <= accept ? sel_oh : 3'h0;
            err_reg <= ((accept && viol) ? sel_oh : 3'h0) |
                       ((i_core_rvalid && par_bad) ? rv_oh : 3'h0);
        end
    end

    // Read data still loads on a parity failure but is not flagged valid to the requester
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rvalid_reg <= 3'h0;
            rdata_reg <= 16'h0000;
        end else begin
            rvalid_reg <= (i_core_rvalid && !par_bad) ? rv_oh : 3'h0;
            if (i_core_rvalid) begin
                rdata_reg <= i_core_rdata[15:0];
            end
        end
    end

    // Trap rather than interrupt, so the faulting access is never completed
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            trap_reg <= 1'b0;
            cause_reg <= 2'h0;
        end else begin
            trap_reg <= (accept && viol) || (i_core_rvalid && par_bad);
            cause_reg[CAUSE_PROT_BIT] <= accept && viol;
            cause_reg[CAUSE_PAR_BIT] <= i_core_rvalid && par_bad;
        end
    end

    assign o_core = core_reg;
    assign o_gnt = gnt_reg;
    assign o_rvalid = rvalid_reg;
    assign o_rdata = rdata_reg;
    assign o_err = err_reg;
    assign o_trap = trap_reg;
    assign o_trap_cause = cause_reg;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_abort;
        !o_core.valid && o_trap;
    endsequence

    // A protection trap from another requester may share the cycle with a good read
    sequence s_read_ok;
        (o_rvalid != 3'h0) && !o_trap_cause[CAUSE_PAR_BIT];
    endsequence

    AST_PRIO: assert property ((i_disc.req && !o_gnt[0]) |=> !o_gnt[1] && !o_gnt[2])
        else $error("lower requester granted over disc");
    AST_DAC_OVER_CPU: assert property ((i_dac.req && !o_gnt[1] && !i_disc.req)
        |=> !o_gnt[2])
        else $error("processor granted over channel");
    AST_NOMAP: assert property ((issue && !map_on)
        |=> {o_core.mod, o_core.addr} == $past(sel.addr))
        else $error("unmapped address altered");
    AST_XLATE: assert property ((issue && map_on)
        |=> {o_core.mod, o_core.addr[11:8]} == $past(map_ent.page)
            && o_core.addr[7:0] == $past(sel.addr[7:0]))
        else $error("mapped address not relocated");
    AST_PROT: assert property ((accept && viol) |=> s_abort ##0 o_trap_cause[0])
        else $error("violation not suppressed and trapped");
    AST_RO: assert property ((|sel_oh && map_on && map_ent.prot == PROT_RO && sel.we)
        |=> !o_core.valid && (o_err != 3'h0))
        else $error("write to read-only page issued");
    AST_PAR_GEN: assert property ((o_core.valid && o_core.we) |-> ^o_core.wdata)
        else $error("write parity wrong");
    AST_PAR_ABORT: assert property ((i_core_rvalid && par_bad)
        |=> o_trap && o_trap_cause[1] && o_rvalid == 3'h0)
        else $error("parity error not aborted");
    AST_PAR_OK: assert property ((i_core_rvalid && !par_bad)
        |=> s_read_ok ##0 o_rdata == $past(i_core_rdata[15:0]))
        else $error("good read not delivered");
    // Module busy shows late, so only the pending flag holds off the next cycle
    AST_BUSY: assert property ((o_core.valid && !o_core.we)
        |=> !(o_core.valid && o_core.mod == $past(o_core.mod)))
        else $error("issue to module with read outstanding");
endmodule : pmm_ctrl

/* rtl/pmm_map_ram.sv */
// Purpose: Shared types and constants, plus the page map store.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   The map is read combinationally and written one entry per clock.

// ---------------------------------------------------------------
// Package
// ---------------------------------------------------------------
package pmm_pkg;
    localparam int unsigned PAGE_WORDS = 256;
    localparam int unsigned LOG_WORDS_EXT = 65536;
    localparam int unsigned NUM_PAGES = LOG_WORDS_EXT / PAGE_WORDS;
    localparam int unsigned NUM_MODS = 16;
    localparam int unsigned MOD_WORDS = 4096;
    localparam logic EXT_OPT = 1'b1;      // Extended 65,536-word logical space fitted
    localparam logic PAR_OPT = 1'b1;      // Parity option fitted
    localparam int unsigned PSD_MAP_BIT = 30;
    localparam int unsigned PSD_IM_BIT = 29;
    localparam int unsigned PSD_MC_BIT = 31;
    localparam logic [1:0] PROT_NONE = 2'h0;
    localparam logic [1:0] PROT_RO = 2'h1;
    localparam logic [1:0] PROT_RW = 2'h3;
    localparam logic [2:0] OH_DISC = 3'h1;
    localparam logic [2:0] OH_DAC = 3'h2;
    localparam logic [2:0] OH_CPU = 3'h4;
    localparam logic [1:0] ID_DISC = 2'h0;
    localparam logic [1:0] ID_DAC = 2'h1;
    localparam logic [1:0] ID_CPU = 2'h2;
    localparam int unsigned CAUSE_PROT_BIT = 0;
    localparam int unsigned CAUSE_PAR_BIT = 1;

    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pmm_req_t;

    typedef struct packed {
        logic [7:0] page;
        logic [1:0] prot;
    } pmm_map_t;

    typedef struct packed {
        logic valid;
        logic we;
        logic [3:0] mod;
        logic [11:0] addr;
        logic [16:0] wdata;
    } pmm_core_t;

    localparam pmm_map_t MAP_RST = '{page: 8'h00, prot: PROT_NONE};
endpackage : pmm_pkg

// ---------------------------------------------------------------
// Page map store
// ---------------------------------------------------------------
module pmm_map_ram
    import pmm_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_wr,
    input wire logic [7:0] i_widx,
    input wire pmm_map_t i_went,
    input wire logic [7:0] i_ridx,
    output pmm_map_t o_rent
);
    pmm_map_t map_reg [NUM_PAGES];

    // Entries reset to no access so nothing mapped leaks before loading
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int k = 0; k < NUM_PAGES; k++) begin
                map_reg[k] <= MAP_RST;
            end
        end else if (i_wr) begin
            map_reg[i_widx] <= i_went;
        end
    end

    // Read is combinational so lookup costs no extra cycle
    assign o_rent = map_reg[i_ridx];
endmodule : pmm_map_ram

/* test/pmm_core_model.sv */
// Purpose: Behavioural core modules facing the controller's core port.
// Assumes: One read in flight per module, fixed module cycle of LAT clocks.
// Notes:   Idle data line toggles so stale data never passes for a return.
module pmm_core_model
    import pmm_pkg::*;
#(
    parameter int LAT = 6
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire pmm_core_t i_core,
    input wire logic i_bad_par,
    output logic [15:0] o_busy,
    output logic o_rvalid,
    output logic [3:0] o_rmod,
    output logic [16:0] o_rdata
);
    logic [16:0] mem [65536];
    int cnt [16];
    logic [15:0] rd_pend;
    logic [11:0] rd_addr [16];

    // Module cycle: busy while counting, a read answers on the last count.
    // Non-blocking so busy never changes inside the edge the controller samples.
    always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt <= '{default: 0};
            rd_pend <= '0;
            o_rvalid <= 1'b0;
            o_rmod <= 4'h0;
            o_rdata <= 17'h0_0000;
        end else begin
            o_rvalid <= 1'b0;
            o_rdata <= ~o_rdata;
            for (int m = 0; m < 16; m++) begin
                if (cnt[m] == 1 && rd_pend[m]) begin
                    o_rvalid <= 1'b1;
                    o_rmod <= 4'(m);
                    // Forced fault flips the stored parity bit only
                    o_rdata <= mem[{4'(m), rd_addr[m]}] ^ {i_bad_par, 16'h0000};
                    rd_pend[m] <= 1'b0;
                end
                if (cnt[m] > 0) cnt[m] <= cnt[m] - 1;
            end
            if (i_core.valid) begin
                cnt[i_core.mod] <= LAT;
                if (i_core.we) begin
                    mem[{i_core.mod, i_core.addr}] <= i_core.wdata;
                end else begin
                    rd_pend[i_core.mod] <= 1'b1;
                    rd_addr[i_core.mod] <= i_core.addr;
                end
            end
        end
    end

    // Busy per module, independent of the others
    always_comb begin
        for (int m = 0; m < 16; m++) o_busy[m] = (cnt[m] != 0);
    end
endmodule : pmm_core_model

/* test/testbench.sv */
// Purpose: Self-checking bench for the paged memory map controller.
// Assumes: Inputs change on the falling edge; core model answers reads.
// Notes:   Accesses run one at a time except in the priority test.
module testbench
    import pmm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk, i_rstn, i_map_wr, bad_par, core_rvalid, o_trap, e_seen, t_seen, rv_seen;
    pmm_req_t rq [3];
    logic [31:0] i_psd;
    logic [7:0] i_map_idx;
    pmm_map_t i_map_ent;
    logic [15:0] core_busy, o_rdata, rd_seen;
    logic [3:0] core_rmod;
    logic [16:0] core_rdata;
    pmm_core_t o_core, c_seen;
    logic [2:0] o_gnt, o_rvalid, o_err;
    logic [1:0] o_trap_cause, tc_seen;
    int mismatches, comparisons;

    pmm_ctrl pmm_ctrl_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_disc(rq[0]), .i_dac(rq[1]),
        .i_cpu(rq[2]), .i_psd(i_psd), .i_map_wr(i_map_wr), .i_map_idx(i_map_idx),
        .i_map_ent(i_map_ent), .i_core_busy(core_busy), .i_core_rvalid(core_rvalid),
        .i_core_rmod(core_rmod), .i_core_rdata(core_rdata), .o_core(o_core), .o_gnt(o_gnt),
        .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_err(o_err), .o_trap(o_trap),
        .o_trap_cause(o_trap_cause));
    pmm_core_model pmm_core_model_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_core(o_core),
        .i_bad_par(bad_par), .o_busy(core_busy), .o_rvalid(core_rvalid), .o_rmod(core_rmod),
        .o_rdata(core_rdata));

    task automatic chk_bit(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit

    task automatic chk_vec(input string n, input logic [16:0] e, input logic [16:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk_vec

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    // One map entry, a single-cycle strobe
    task automatic map_set(input logic [7:0] idx, input logic [7:0] pg, input logic [1:0] pr);
        @(negedge i_ref_clk);
        i_map_wr = 1'b1;
        i_map_idx = idx;
        i_map_ent = '{page: pg, prot: pr};
        @(negedge i_ref_clk);
        i_map_wr = 1'b0;
    endtask : map_set

    // Request held until granted; a read then waits for its data or abort
    task automatic access(input int w, input logic we, input logic [15:0] a, input logic [15:0] d);
        int n;
        @(negedge i_ref_clk);
        rq[w] = '{req: 1'b1, we: we, addr: a, wdata: d};
        n = 0;
        do begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end while (o_gnt[w] !== 1'b1 && n < 50);
        // A grant that never comes counts as a failure, not a silent skip
        chk_bit("grant", 1'b1, o_gnt[w]);
        c_seen = o_core;
        e_seen = o_err[w];
        t_seen = o_trap;
        tc_seen = o_trap_cause;
        rv_seen = 1'b0;
        @(negedge i_ref_clk);
        rq[w].req = 1'b0;
        if (!we && e_seen !== 1'b1) begin
            n = 0;
            do begin
                @(posedge i_ref_clk);
                #1;
                n++;
            end while (o_rvalid[w] !== 1'b1 && o_err[w] !== 1'b1 && n < 50);
            chk_bit("answer", 1'b1, o_rvalid[w] | o_err[w]);
            rv_seen = o_rvalid[w];
            e_seen = o_err[w];
            t_seen = o_trap;
            tc_seen = o_trap_cause;
            rd_seen = o_rdata;
        end
    endtask : access

    task automatic t_plain();
        access(2, 1'b1, 16'h1234, 16'hbeef);
        chk_vec("mod", 17'h0_0001, 17'(c_seen.mod));
        chk_vec("addr", 17'h0_0234, 17'(c_seen.addr));
        chk_bit("we", 1'b1, c_seen.we);
        chk_vec("wdata", 17'h0_beef, c_seen.wdata);
        access(2, 1'b0, 16'h1234, 16'h0000);
        chk_bit("rwe", 1'b0, c_seen.we);
        chk_vec("rdata", 17'h0_beef, 17'(rd_seen));
        $display("test plain done");
    endtask : t_plain

    task automatic t_map();
        map_set(8'h05, 8'h3a, PROT_RW);
        map_set(8'h80, 8'h3a, PROT_RW);
        @(negedge i_ref_clk);
        i_psd = 32'h4000_0000;
        access(2, 1'b1, 16'h0512, 16'h5a0f);
        chk_vec("mod", 17'h0_0003, 17'(c_seen.mod));
        chk_vec("addr", 17'h0_0a12, 17'(c_seen.addr));
        access(1, 1'b0, 16'h0512, 16'h0000);
        chk_vec("rdata", 17'h0_5a0f, 17'(rd_seen));
        access(0, 1'b0, 16'h8012, 16'h0000);
        chk_vec("rdata", 17'h0_5a0f, 17'(rd_seen));
        $display("test map done");
    endtask : t_map

    // Every protection code, write by processor then read by disc
    task automatic t_prot();
        for (int k = 3; k >= 0; k--) begin
            map_set(8'h06, 8'h21, 2'(k));
            access(2, 1'b1, 16'h0605, 16'h1357);
            chk_bit("werr", k != 3, e_seen);
            chk_bit("wcore", k == 3, c_seen.valid);
            chk_bit("wtrap", k != 3, t_seen);
            access(0, 1'b0, 16'h0605, 16'h0000);
            chk_bit("rerr", k % 2 == 0, e_seen);
            if (k % 2 == 0) chk_vec("cause", 17'h0_0001, 17'(tc_seen));
            else chk_vec("rdata", 17'h0_1357, 17'(rd_seen));
        end
        $display("test prot done");
    endtask : t_prot

    task automatic t_prio();
        int t [3];
        @(negedge i_ref_clk);
        i_psd = 32'h0000_0000;
        for (int w = 0; w < 3; w++) begin
            rq[w] = '{req: 1'b1, we: 1'b1, addr: {4'(w + 2), 12'h010}, wdata: 16'h0c00};
            t[w] = -1;
        end
        for (int k = 0; k < 12; k++) begin
            @(posedge i_ref_clk);
            #1;
            for (int w = 0; w < 3; w++) if (o_gnt[w] === 1'b1) t[w] = k;
            @(negedge i_ref_clk);
            for (int w = 0; w < 3; w++) if (t[w] >= 0) rq[w].req = 1'b0;
        end
        chk_bit("order", 1'b1, t[0] >= 0 && t[0] < t[1] && t[1] < t[2]);
        chk_bit("overlap", 1'b1, t[2] - t[0] < 6);
        $display("test prio done");
    endtask : t_prio

    task automatic t_par();
        access(2, 1'b1, 16'h5100, 16'h00ff);
        @(negedge i_ref_clk);
        bad_par = 1'b1;
        access(2, 1'b0, 16'h5100, 16'h0000);
        chk_bit("rvalid", 1'b0, rv_seen);
        chk_bit("perr", 1'b1, e_seen);
        chk_bit("ptrap", 1'b1, t_seen);
        chk_vec("cause", 17'h0_0002, 17'(tc_seen));
        @(negedge i_ref_clk);
        bad_par = 1'b0;
        access(2, 1'b0, 16'h5100, 16'h0000);
        chk_vec("rdata", 17'h0_00ff, 17'(rd_seen));
        $display("test parity done");
    endtask : t_par

    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        i_rstn = 1'b0;
        i_map_wr = 1'b0;
        bad_par = 1'b0;
        i_psd = 32'h0000_0000;
        i_map_idx = 8'h00;
        i_map_ent = '{page: 8'h00, prot: PROT_NONE};
        rq = '{default: '0};
        mismatches = 0;
        comparisons = 0;
        repeat (12) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_rstn = 1'b1;
        chk_vec("idle", 17'h0_0000, 17'({o_gnt, o_rvalid, o_err, o_trap, o_core.valid}));
        t_plain();
        t_map();
        t_prot();
        t_prio();
        t_par();
        report_and_stop();
    end
endmodule : testbench
